/* logic/sibk_pkg.sv */
/*
 * Package for the banked serial/infrared control registers (banks 2 to 5).
 * Holds offsets, field positions, reset values and encodings.
 * Assumes an 8-bit register port with a 3-bit offset and a bank decode.
 */
// Operation
// (R1) Depth codes: 00=16, 01=32, 1x reserved, FIFOs enabled
// (R2) Prescaler bits 5:4: 13, 1.625, reserved, 1.0
// (R3) Extended control register clears on reset
// (R4) Lock blocks legacy divisor access and fallback
// (R5) Locked legacy divisor ports reach scratchpads
// (R6) Software keeps lock zero in extended mode
// (R7) Bank 2 offset 06h reads transmit count
// (R8) Bank 2 offset 07h reads receive count
// (R9) Software reads counts three times
// (R10) Bank 3 offset 00h returns fixed revision byte
// (R11) Bank 3 offset 01h returns line control
// (R12) Offset 03h write updates line control
// (R13) Bank 3 offset 02h returns queue control
// (R14) Offset 03h in banks 2-5 shared
// (R15) Infrared mode bits 3:2, reset zero
// (R16) Infrared mode ignored in extended mode
// (R17) Software clears infrared mode after use
// (R18) Reserved locations read zero
// (R19) Extended mode bit selects extended operation
// (R20) Level counters follow push and pop
package sibk_pkg;
    // Offsets within a bank
    localparam logic [2:0] SIBK_OFS_DIV_LO   = 3'h0;
    localparam logic [2:0] SIBK_OFS_DIV_HI   = 3'h1;
    localparam logic [2:0] SIBK_OFS_REV      = 3'h0;
    localparam logic [2:0] SIBK_OFS_LCR_SH   = 3'h1;
    localparam logic [2:0] SIBK_OFS_QCR_SH   = 3'h2;
    localparam logic [2:0] SIBK_OFS_LINE     = 3'h3;
    localparam logic [2:0] SIBK_OFS_EXTCTL   = 3'h4;
    localparam logic [2:0] SIBK_OFS_TXLVL    = 3'h6;
    localparam logic [2:0] SIBK_OFS_RXLVL    = 3'h7;
    localparam logic [2:0] SIBK_OFS_IRMODE   = 3'h2;
    // Bank numbers
    localparam logic [2:0] SIBK_BANK_LEGACY  = 3'h1;
    localparam logic [2:0] SIBK_BANK_EXT     = 3'h2;
    localparam logic [2:0] SIBK_BANK_SHADOW  = 3'h3;
    localparam logic [2:0] SIBK_BANK_IR      = 3'h4;
    // Field positions of the extended control and infrared mode registers
    localparam int SIBK_TXDEP_LSB = 0;
    localparam int SIBK_RXDEP_LSB = 2;
    localparam int SIBK_PRE_LSB   = 4;
    localparam int SIBK_LOCK_BIT  = 7;
    localparam int SIBK_IRM_LSB   = 2;
    // Writable and count masks; reserved bits stay zero
    localparam logic [7:0] SIBK_EXTCTL_WMASK = 8'hBF;
    localparam logic [7:0] SIBK_IRMODE_WMASK = 8'h0C;
    localparam logic [7:0] SIBK_CNT_MASK     = 8'h3F;
    // Reset values
    localparam logic [7:0] SIBK_RST_EXTCTL = 8'h00;
    localparam logic [7:0] SIBK_RST_IRMODE = 8'h00;
    localparam logic [7:0] SIBK_RST_LINE   = 8'h00;
    // Depth codes and depths
    localparam logic [1:0] SIBK_DEP_16 = 2'h0;
    localparam logic [1:0] SIBK_DEP_32 = 2'h1;
    localparam logic [5:0] SIBK_DEPTH_16 = 6'h10;
    localparam logic [5:0] SIBK_DEPTH_32 = 6'h20;
    // Prescaler codes, ratio in sixteenths: 13=208, 1.625=26, 1.0=16
    localparam logic [1:0] SIBK_PRE_13  = 2'h0;
    localparam logic [1:0] SIBK_PRE_1P6 = 2'h1;
    localparam logic [1:0] SIBK_PRE_RSV = 2'h2;
    localparam logic [1:0] SIBK_PRE_1   = 2'h3;
    localparam logic [7:0] SIBK_PRE16_13  = 8'hD0;
    localparam logic [7:0] SIBK_PRE16_1P6 = 8'h1A;
    localparam logic [7:0] SIBK_PRE16_1   = 8'h10;
    // Infrared modes
    typedef enum logic [1:0] {
        SIBK_IR_UART  = 2'b00,
        SIBK_IR_RSV   = 2'b01,
        SIBK_IR_CARR  = 2'b10,
        SIBK_IR_SIR   = 2'b11
    } sibk_irmode_t;
endpackage

/* logic/sibk_regs.sv */
/*
 * Banked control and status registers of the serial/infrared module,
 * banks 2 to 5, plus the shared line control at offset 03h.
 * Assumes the bank index is decoded outside from the bank select, the
 * queue control byte lives elsewhere, and push/pop strobes come from the
 * queues themselves, synchronous to i_core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sibk_regs
    import sibk_pkg::*;
#(
    parameter logic [3:0] MODULE_TYPE = 4'h5, // Arbitrary value
    parameter logic [3:0] REVISION    = 4'h1  // Arbitrary value
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_srst,
    input  wire logic [2:0] i_bank,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_line_is_lcr,
    input  wire logic       i_ext_mode,
    input  wire logic [7:0] i_queue_control,
    input  wire logic       i_fifo_en,
    input  wire logic       i_tx_push,
    input  wire logic       i_tx_pop,
    input  wire logic       i_rx_push,
    input  wire logic       i_rx_pop,
    output logic      [7:0] o_rdata,
    output logic      [7:0] o_line_control,
    output logic      [5:0] o_tx_depth,
    output logic      [5:0] o_rx_depth,
    output logic      [7:0] o_prescale16,
    output logic            o_div_lock,
    output logic            o_fallback_en,
    output logic            o_legacy_div_wr,
    output logic      [1:0] o_ir_mode
);
    logic [7:0] extctl_r;     // Depth, prescaler, lock
    logic [7:0] irmode_r;     // Infrared legacy select
    logic [7:0] line_r;       // Shared line control
    logic [7:0] scratch_lo_r; // Overlay of low divisor port
    logic [7:0] scratch_hi_r; // Overlay of high divisor port
    logic [5:0] tx_cnt_r;     // Transmit occupancy
    logic [5:0] rx_cnt_r;     // Receive occupancy
    logic       wr_ext;
    logic       wr_ir;
    logic       lock_hit;

    // Depth from code; reserved codes fall back to 16
    function automatic logic [5:0] depth_of(input logic [1:0] code, input logic en);
        depth_of = (en && code == SIBK_DEP_32) ? SIBK_DEPTH_32 : SIBK_DEPTH_16; // [R1]
    endfunction

    // Occupancy update, saturating at the configured depth
    function automatic logic [5:0] cnt_next(input logic [5:0] c, input logic push,
                                            input logic pop, input logic [5:0] dep);
        cnt_next = c;
        if (push && !pop && c < dep) begin
            cnt_next = c + 6'h01; // [R20]
        end else if (pop && !push && c != 6'h00) begin
            cnt_next = c - 6'h01; // [R20]
        end
    endfunction

    assign wr_ext   = i_wr && i_bank == SIBK_BANK_EXT;
    assign wr_ir    = i_wr && i_bank == SIBK_BANK_IR && i_addr == SIBK_OFS_IRMODE;
    // Locked legacy divisor access from non-extended mode only
    assign lock_hit = extctl_r[SIBK_LOCK_BIT] && !i_ext_mode && i_bank == SIBK_BANK_LEGACY
                      && (i_addr == SIBK_OFS_DIV_LO || i_addr == SIBK_OFS_DIV_HI);

    // Extended control register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            extctl_r <= SIBK_RST_EXTCTL; // [R3]
        end else if (wr_ext && i_addr == SIBK_OFS_EXTCTL) begin
            extctl_r <= i_wdata & SIBK_EXTCTL_WMASK;
        end
    end

    // Infrared mode register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            irmode_r <= SIBK_RST_IRMODE; // [R15]
        end else if (wr_ir) begin
            irmode_r <= i_wdata & SIBK_IRMODE_WMASK; // [R15]
        end
    end

    // Line control, shared by every bank at offset 03h
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            line_r <= SIBK_RST_LINE;
        end else if (i_wr && i_addr == SIBK_OFS_LINE && i_line_is_lcr) begin
            line_r <= i_wdata; // [R12] [R14]
        end
    end

    // Scratchpads replace the divisor while locked outside extended mode
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            scratch_lo_r <= 8'h00;
            scratch_hi_r <= 8'h00;
        end else if (i_wr && lock_hit) begin
            if (i_addr == SIBK_OFS_DIV_LO) begin
                scratch_lo_r <= i_wdata; // [R5]
            end else begin
                scratch_hi_r <= i_wdata; // [R5]
            end
        end
    end

    // Occupancy counters
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            tx_cnt_r <= 6'h00;
            rx_cnt_r <= 6'h00;
        end else begin
            tx_cnt_r <= cnt_next(tx_cnt_r, i_tx_push, i_tx_pop, o_tx_depth);
            rx_cnt_r <= cnt_next(rx_cnt_r, i_rx_push, i_rx_pop, o_rx_depth);
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk) begin
        if (i_srst || !i_rd) begin
            o_rdata <= 8'h00;
        end else if (i_addr == SIBK_OFS_LINE) begin
            o_rdata <= line_r; // [R14]
        end else begin
            unique case (i_bank)
                SIBK_BANK_LEGACY: begin
                    // Only the locked overlay is served here
                    if (lock_hit) begin
                        o_rdata <= (i_addr == SIBK_OFS_DIV_LO) ? scratch_lo_r : scratch_hi_r; // [R5]
                    end else begin
                        o_rdata <= 8'h00;
                    end
                end
                SIBK_BANK_EXT: begin
                    if (i_addr == SIBK_OFS_EXTCTL) begin
                        o_rdata <= extctl_r;
                    end else if (i_addr == SIBK_OFS_TXLVL) begin
                        o_rdata <= {2'b00, tx_cnt_r}; // [R7]
                    end else if (i_addr == SIBK_OFS_RXLVL) begin
                        o_rdata <= {2'b00, rx_cnt_r}; // [R8]
                    end else begin
                        o_rdata <= 8'h00; // [R18]
                    end
                end
                SIBK_BANK_SHADOW: begin
                    if (i_addr == SIBK_OFS_REV) begin
                        o_rdata <= {MODULE_TYPE, REVISION}; // [R10]
                    end else if (i_addr == SIBK_OFS_LCR_SH) begin
                        o_rdata <= line_r; // [R11]
                    end else if (i_addr == SIBK_OFS_QCR_SH) begin
                        o_rdata <= i_queue_control; // [R13]
                    end else begin
                        o_rdata <= 8'h00; // [R18]
                    end
                end
                SIBK_BANK_IR: begin
                    o_rdata <= (i_addr == SIBK_OFS_IRMODE) ? irmode_r : 8'h00; // [R18]
                end
                default: begin
                    // Banks outside this block and bank 5 read zero
                    o_rdata <= 8'h00; // [R18]
                end
            endcase
        end
    end

    // Registered control outputs
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_line_control  <= 8'h00;
            o_tx_depth      <= SIBK_DEPTH_16;
            o_rx_depth      <= SIBK_DEPTH_16;
            o_prescale16    <= SIBK_PRE16_13;
            o_div_lock      <= 1'b0;
            o_fallback_en   <= 1'b1;
            o_legacy_div_wr <= 1'b0;
            o_ir_mode       <= SIBK_IR_UART;
        end else begin
            o_line_control <= line_r;
            o_tx_depth     <= depth_of(extctl_r[SIBK_TXDEP_LSB +: 2], i_fifo_en); // [R1]
            o_rx_depth     <= depth_of(extctl_r[SIBK_RXDEP_LSB +: 2], i_fifo_en); // [R1]
            unique case (extctl_r[SIBK_PRE_LSB +: 2])
                SIBK_PRE_13:  o_prescale16 <= SIBK_PRE16_13;  // [R2]
                SIBK_PRE_1P6: o_prescale16 <= SIBK_PRE16_1P6; // [R2]
                SIBK_PRE_RSV: o_prescale16 <= SIBK_PRE16_13;  // Reserved holds default
                SIBK_PRE_1:   o_prescale16 <= SIBK_PRE16_1;   // [R2]
            endcase
            o_div_lock    <= extctl_r[SIBK_LOCK_BIT];
            o_fallback_en <= !extctl_r[SIBK_LOCK_BIT]; // [R4]
            // Legacy divisor write passes unless locked outside extended mode
            o_legacy_div_wr <= i_wr && !lock_hit && i_bank == SIBK_BANK_LEGACY
                               && (i_addr == SIBK_OFS_DIV_LO || i_addr == SIBK_OFS_DIV_HI); // [R4]
            // Extended mode masks the legacy infrared select
            o_ir_mode <= i_ext_mode ? SIBK_IR_UART : irmode_r[SIBK_IRM_LSB +: 2]; // [R16] [R19]
        end
    end

    // Assertions
    property p_rst_clear;
        @(posedge i_core_clk) i_srst |=> extctl_r == 8'h00 && o_prescale16 == SIBK_PRE16_13;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset left control set"); // [R3]
    property p_lock_blocks;
        @(posedge i_core_clk) disable iff (i_srst) (i_wr && lock_hit) |=> !o_legacy_div_wr;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked divisor write passed"); // [R4]
    property p_scratch;
        @(posedge i_core_clk) disable iff (i_srst)
            (i_wr && lock_hit && i_addr == SIBK_OFS_DIV_LO) ##1 (i_rd && lock_hit && i_addr == SIBK_OFS_DIV_LO)
            |=> o_rdata == $past(i_wdata, 2);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratchpad readback wrong"); // [R5]
    property p_txlvl;
        @(posedge i_core_clk) disable iff (i_srst)
            (i_rd && i_bank == SIBK_BANK_EXT && i_addr == SIBK_OFS_TXLVL) |=> o_rdata == {2'b00, $past(tx_cnt_r)};
    endproperty
    a_txlvl: assert property (p_txlvl) else $error("transmit count read wrong"); // [R7]
    property p_rev;
        @(posedge i_core_clk) disable iff (i_srst)
            (i_rd && i_bank == SIBK_BANK_SHADOW && i_addr == SIBK_OFS_REV) |=> o_rdata == {MODULE_TYPE, REVISION};
    endproperty
    a_rev: assert property (p_rev) else $error("revision byte wrong"); // [R10]
    property p_line_wr;
        @(posedge i_core_clk) disable iff (i_srst)
            (i_wr && i_addr == SIBK_OFS_LINE && i_line_is_lcr) |=> ##1 o_line_control == $past(i_wdata, 2);
    endproperty
    a_line_wr: assert property (p_line_wr) else $error("line control not updated"); // [R12]
    property p_ir_ext;
        @(posedge i_core_clk) disable iff (i_srst) i_ext_mode |=> o_ir_mode == SIBK_IR_UART;
    endproperty
    a_ir_ext: assert property (p_ir_ext) else $error("infrared select active in extended mode"); // [R16]
    property p_rsv_zero;
        @(posedge i_core_clk) disable iff (i_srst)
            (i_rd && i_bank == SIBK_BANK_EXT && i_addr == 3'h5) |=> o_rdata == 8'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero"); // [R18]
    property p_cnt_inc;
        @(posedge i_core_clk) disable iff (i_srst)
            (i_tx_push && !i_tx_pop && tx_cnt_r < o_tx_depth) |=> tx_cnt_r == $past(tx_cnt_r) + 6'h01;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("transmit count missed push"); // [R20]
    c_lock: cover property (@(posedge i_core_clk) i_wr && lock_hit);
    c_full: cover property (@(posedge i_core_clk) tx_cnt_r == SIBK_DEPTH_32);
    c_sir:  cover property (@(posedge i_core_clk) o_ir_mode == SIBK_IR_SIR);
endmodule
`default_nettype wire

/* dv/tb_top.sv */
/*
 * Self-checking bench for the banked serial/infrared control registers.
 * Assumes the register port of sibk_regs, 20 MHz clock, sync active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sibk_pkg::*;
    logic       i_core_clk, i_srst, i_wr, i_rd, i_line_is_lcr, i_ext_mode, i_fifo_en;
    logic       i_tx_push, i_tx_pop, i_rx_push, i_rx_pop;
    logic [2:0] i_bank, i_addr;
    logic [7:0] i_wdata, i_queue_control, o_rdata, o_line_control, o_prescale16;
    logic [5:0] o_tx_depth, o_rx_depth;
    logic [1:0] o_ir_mode;
    logic       o_div_lock, o_fallback_en, o_legacy_div_wr;
    int         num_errors = 0;
    int         n_tests = 0;

    sibk_regs dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_bank(i_bank), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_line_is_lcr(i_line_is_lcr),
        .i_ext_mode(i_ext_mode), .i_queue_control(i_queue_control), .i_fifo_en(i_fifo_en),
        .i_tx_push(i_tx_push), .i_tx_pop(i_tx_pop), .i_rx_push(i_rx_push), .i_rx_pop(i_rx_pop),
        .o_rdata(o_rdata), .o_line_control(o_line_control), .o_tx_depth(o_tx_depth),
        .o_rx_depth(o_rx_depth), .o_prescale16(o_prescale16), .o_div_lock(o_div_lock),
        .o_fallback_en(o_fallback_en), .o_legacy_div_wr(o_legacy_div_wr), .o_ir_mode(o_ir_mode));

    // Free-running 50 ns clock
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    // Every compare funnels through here so counts stay honest
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // One-cycle write strobe, released at the edge that takes it
    task automatic wr(input logic [2:0] b, input logic [2:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_bank  <= b;
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] b, input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_bank <= b;
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    // Control outputs trail a write by two edges
    task automatic settle();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask

    // Separate one-cycle pulses on a queue strobe: 0 tx push, 1 tx pop, 2 rx push, 3 rx pop
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            case (sel)
                0:       i_tx_push <= 1'b1;
                1:       i_tx_pop  <= 1'b1;
                2:       i_rx_push <= 1'b1;
                default: i_rx_pop  <= 1'b1;
            endcase
            @(posedge i_core_clk);
            {i_tx_push, i_tx_pop, i_rx_push, i_rx_pop} <= 4'h0;
        end
    endtask

    task automatic t_reset();
        #1;
        chk({2'h0, o_tx_depth}, 8'h10);
        chk({2'h0, o_rx_depth}, 8'h10);
        chk(o_prescale16, SIBK_PRE16_13);
        chk({6'h00, o_div_lock, o_fallback_en}, 8'h01);
        rd_chk(3'h2, 3'h4, 8'h00);
    endtask

    task automatic t_extctl();
        logic [7:0] exp_pre [4];
        exp_pre = '{SIBK_PRE16_13, SIBK_PRE16_1P6, SIBK_PRE16_13, SIBK_PRE16_1};
        // Every prescaler code, the reserved one falls back to 13
        for (int c = 0; c < 4; c++) begin
            wr(3'h2, 3'h4, 8'(c << 4));
            settle();
            chk(o_prescale16, exp_pre[c]);
        end
        wr(3'h2, 3'h4, 8'h05);
        settle();
        chk({o_tx_depth, 2'h0}, 8'h80);
        chk({o_rx_depth, 2'h0}, 8'h80);
        wr(3'h2, 3'h4, 8'h0A);             // Reserved depth codes
        settle();
        chk({2'h0, o_tx_depth}, 8'h10);
        i_fifo_en <= 1'b0;
        wr(3'h2, 3'h4, 8'h05);             // Depth only counts while queues run
        settle();
        chk({2'h0, o_rx_depth}, 8'h10);
        i_fifo_en <= 1'b1;
        wr(3'h2, 3'h4, 8'hFF);
        rd_chk(3'h2, 3'h4, 8'hBF);
        wr(3'h2, 3'h4, 8'h00);
    endtask

    task automatic t_lock();
        wr(3'h1, 3'h0, 8'h33);             // Unlocked legacy divisor write
        #1;
        chk({7'h00, o_legacy_div_wr}, 8'h01);
        rd_chk(3'h1, 3'h0, 8'h00);
        wr(3'h2, 3'h4, 8'h80);
        settle();
        chk({6'h00, o_div_lock, o_fallback_en}, 8'h02);
        wr(3'h1, 3'h0, 8'h5A);
        #1;
        chk({7'h00, o_legacy_div_wr}, 8'h00);
        wr(3'h1, 3'h1, 8'hA5);
        rd_chk(3'h1, 3'h0, 8'h5A);
        rd_chk(3'h1, 3'h1, 8'hA5);
        // Write then read with no gap between the strobes
        @(posedge i_core_clk);
        i_bank  <= 3'h1;
        i_addr  <= 3'h0;
        i_wdata <= 8'h6C;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
        i_rd    <= 1'b1;
        @(posedge i_core_clk);
        i_rd    <= 1'b0;
        #1;
        chk(o_rdata, 8'h6C);
        wr(3'h2, 3'h4, 8'h00);             // Lock back off before extended mode
    endtask

    task automatic t_levels();
        pulse(0, 17);                      // One past a 16-deep queue
        rd_chk(3'h2, 3'h6, 8'h10);
        pulse(1, 1);
        rd_chk(3'h2, 3'h6, 8'h0F);
        pulse(2, 3);
        pulse(3, 1);
        rd_chk(3'h2, 3'h7, 8'h02);
        // Three reads in a row, as software does against a moving count
        rd_chk(3'h2, 3'h7, 8'h02);
        rd_chk(3'h2, 3'h7, 8'h02);
        rd_chk(3'h2, 3'h7, 8'h02);
    endtask

    task automatic t_bank3();
        wr(3'h3, 3'h0, 8'hFF);             // Read-only, write must not stick
        rd_chk(3'h3, 3'h0, 8'h51);
        i_line_is_lcr <= 1'b1;
        wr(3'h4, 3'h3, 8'h3B);
        settle();
        chk(o_line_control, 8'h3B);
        rd_chk(3'h3, 3'h1, 8'h3B);
        rd_chk(3'h3, 3'h1, 8'h3B);
        rd_chk(3'h5, 3'h3, 8'h3B);
        i_line_is_lcr <= 1'b0;
        wr(3'h2, 3'h3, 8'h02);             // Bank select byte leaves line control
        rd_chk(3'h3, 3'h1, 8'h3B);
        rd_chk(3'h3, 3'h2, 8'hC7);
    endtask

    task automatic t_irmode();
        for (int c = 0; c < 4; c++) begin
            wr(3'h4, 3'h2, 8'(8'hF3 | (c << 2)));
            settle();
            chk({6'h00, o_ir_mode}, 8'(c));
            rd_chk(3'h4, 3'h2, 8'(c << 2));
        end
        i_ext_mode <= 1'b1;                // Extended operation hides the select
        settle();
        chk({6'h00, o_ir_mode}, 8'h00);
        i_ext_mode <= 1'b0;
        wr(3'h4, 3'h2, 8'h00);             // Back to plain serial
    endtask

    task automatic t_reserved();
        wr(3'h2, 3'h5, 8'h00);             // Only zeros go to reserved
        rd_chk(3'h2, 3'h5, 8'h00);
        rd_chk(3'h3, 3'h4, 8'h00);
        rd_chk(3'h4, 3'h0, 8'h00);
        rd_chk(3'h5, 3'h7, 8'h00);
    endtask

    // Single exit point for the run
    task automatic report_and_stop();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {i_wr, i_rd, i_line_is_lcr, i_ext_mode, i_tx_push, i_tx_pop, i_rx_push, i_rx_pop} = 8'h00;
        i_srst = 1'b1;
        i_fifo_en = 1'b1;
        i_bank = 3'h0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        i_queue_control = 8'hC7;
        repeat (4) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(posedge i_core_clk);
        t_reset();
        t_extctl();
        t_lock();
        t_levels();
        t_bank3();
        t_irmode();
        t_reserved();
        report_and_stop();
    end

    // Whole run is under two hundred cycles; far longer means a hang
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
